/* csf_alu.sv */
/*
  combinational arithmetic unit: binary and decimal add/subtract, logic,
  shifts, bit set/clear, product and quotient, and status flag updates.
  assumes the caller applies o_flags only where o_mask is set.
*/
`timescale 1ns/1ps
module csf_alu (
  input wire csf_pkg::csf_op_t i_op,
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_m,
  input wire logic [7:0] i_y,
  input wire logic [7:0] i_status,
  output logic [7:0] o_res,
  output logic [7:0] o_res_hi,
  output logic [7:0] o_flags,
  output logic [7:0] o_mask
);
  logic c_in;
  logic dec_mode;
  logic [8:0] bin_add;
  logic [8:0] bin_sub;
  logic [4:0] dlo, dhi, slo, shi;
  logic dlo_c, dhi_c, slo_b, shi_b;
  logic [7:0] dec_add, dec_sub;
  logic [15:0] prod;
  logic [15:0] divisor;
  logic [15:0] quo;
  logic [15:0] rem;
  logic c_new, v_new;

  assign c_in = i_status[csf_pkg::FLAG_C];
  assign dec_mode = i_status[csf_pkg::FLAG_D];
  assign bin_add = {1'b0, i_a} + {1'b0, i_m} + {8'h00, c_in};
  assign bin_sub = {1'b0, i_a} - {1'b0, i_m} - {8'h00, ~c_in};

  // decimal add, nibble by nibble
  assign dlo = {1'b0, i_a[3:0]} + {1'b0, i_m[3:0]} + {4'h0, c_in};
  assign dlo_c = dlo > csf_pkg::BCD_MAX;
  assign dhi = {1'b0, i_a[7:4]} + {1'b0, i_m[7:4]} + {4'h0, dlo_c};
  assign dhi_c = dhi > csf_pkg::BCD_MAX;
  assign dec_add[3:0] = dlo_c ? 4'(dlo + csf_pkg::BCD_ADJ) : dlo[3:0];
  assign dec_add[7:4] = dhi_c ? 4'(dhi + csf_pkg::BCD_ADJ) : dhi[3:0];

  // decimal subtract, borrow adjusts by six
  assign slo = {1'b0, i_a[3:0]} - {1'b0, i_m[3:0]} - {4'h0, ~c_in};
  assign slo_b = slo[4];
  assign shi = {1'b0, i_a[7:4]} - {1'b0, i_m[7:4]} - {4'h0, slo_b};
  assign shi_b = shi[4];
  assign dec_sub[3:0] = slo_b ? 4'(slo - csf_pkg::BCD_ADJ) : slo[3:0];
  assign dec_sub[7:4] = shi_b ? 4'(shi - csf_pkg::BCD_ADJ) : shi[3:0];

  // product and quotient ignore mode flags; divide by zero guarded
  assign prod = {8'h00, i_a} * {8'h00, i_m};
  assign divisor = (i_m == 8'h00) ? 16'h0001 : {8'h00, i_m};
  assign quo = {i_y, i_a} / divisor;
  assign rem = {i_y, i_a} % divisor;

  // operation select and flag masks
  always_comb begin
    o_res = i_a;
    o_res_hi = i_y;
    o_mask = 8'h00;
    c_new = c_in;
    v_new = i_status[csf_pkg::FLAG_V];
    o_flags = i_status;
    unique case (i_op)
      csf_pkg::OP_ADD_WITH_CARRY: begin
        o_res = dec_mode ? dec_add : bin_add[7:0];
        c_new = dec_mode ? dhi_c : bin_add[8];
        v_new = (i_a[7] == i_m[7]) && (bin_add[7] != i_a[7]);
        o_mask = 8'hc3;
      end
      csf_pkg::OP_SUBTRACT_WITH_BORROW: begin
        o_res = dec_mode ? dec_sub : bin_sub[7:0];
        c_new = dec_mode ? ~shi_b : ~bin_sub[8];
        v_new = (i_a[7] != i_m[7]) && (bin_sub[7] != i_a[7]);
        o_mask = 8'hc3;
      end
      csf_pkg::OP_AND: begin
        o_res = i_a & i_m;
        o_mask = 8'h82;
      end
      csf_pkg::OP_EXCLUSIVE_OR: begin
        o_res = i_a ^ i_m;
        o_mask = 8'h82;
      end
      csf_pkg::OP_INCLUSIVE_OR: begin
        o_res = i_a | i_m;
        o_mask = 8'h82;
      end
      csf_pkg::OP_ARITH_SHIFT_LEFT: begin
        o_res = {i_a[6:0], 1'b0};
        c_new = i_a[7];
        o_mask = 8'h83;
      end
      csf_pkg::OP_LOGICAL_SHIFT_RIGHT: begin
        o_res = {1'b0, i_a[7:1]};
        c_new = i_a[0];
        o_mask = 8'h83;
      end
      csf_pkg::OP_ROTATE_LEFT_THROUGH_CARRY: begin
        o_res = {i_a[6:0], c_in};
        c_new = i_a[7];
        o_mask = 8'h83;
      end
      csf_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        o_res = {c_in, i_a[7:1]};
        c_new = i_a[0];
        o_mask = 8'h83;
      end
      csf_pkg::OP_ROTATE_RIGHT_NIBBLE: o_res = {i_a[3:0], i_a[7:4]};
      csf_pkg::OP_ADD_ONE: begin
        o_res = 8'(i_a + 8'h01);
        o_mask = 8'h82;
      end
      csf_pkg::OP_SUBTRACT_ONE: begin
        o_res = 8'(i_a - 8'h01);
        o_mask = 8'h82;
      end
      csf_pkg::OP_BITWISE_INVERT: begin
        o_res = ~i_a;
        o_mask = 8'h82;
      end
      csf_pkg::OP_SET_MEMORY_BIT: o_res = i_a | (8'h01 << i_m[csf_pkg::BIT_SEL_MSB:0]);
      csf_pkg::OP_CLEAR_MEMORY_BIT: o_res = i_a & ~(8'h01 << i_m[csf_pkg::BIT_SEL_MSB:0]);
      csf_pkg::OP_PRODUCT: begin
        o_res = prod[7:0];
        o_res_hi = prod[15:8];
      end
      csf_pkg::OP_QUOTIENT: begin
        o_res = (i_m == 8'h00) ? 8'hff : quo[7:0];
        o_res_hi = (i_m == 8'h00) ? i_y : rem[7:0];
      end
      csf_pkg::OP_SET_CARRY_FLAG: begin
        c_new = 1'b1;
        o_mask = 8'h01;
      end
      csf_pkg::OP_CLEAR_CARRY_FLAG: begin
        c_new = 1'b0;
        o_mask = 8'h01;
      end
      csf_pkg::OP_SET_DECIMAL_FLAG: begin
        o_flags[csf_pkg::FLAG_D] = 1'b1;
        o_mask = 8'h08;
      end
      csf_pkg::OP_CLEAR_DECIMAL_FLAG: begin
        o_flags[csf_pkg::FLAG_D] = 1'b0;
        o_mask = 8'h08;
      end
      csf_pkg::OP_SET_INDEX_MODE: begin
        o_flags[csf_pkg::FLAG_T] = 1'b1;
        o_mask = 8'h20;
      end
      csf_pkg::OP_CLEAR_INDEX_MODE: begin
        o_flags[csf_pkg::FLAG_T] = 1'b0;
        o_mask = 8'h20;
      end
      default: o_res = i_a;
    endcase
    o_flags[csf_pkg::FLAG_C] = c_new;
    o_flags[csf_pkg::FLAG_V] = v_new;
    o_flags[csf_pkg::FLAG_N] = o_res[7];
    o_flags[csf_pkg::FLAG_Z] = (o_res == 8'h00);
  end
endmodule

/* csf_pkg.sv */
/*
  shared constants and types for the status-word and read-modify-write core:
  register offsets, status flag positions, reset value, opcodes and states.
  assumes an 8-bit data path and a 16-bit memory address.
*/
package csf_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_OPERAND = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_ACC = 8'h0c;
  localparam logic [7:0] REG_X = 8'h10;
  localparam logic [7:0] REG_Y = 8'h14;
  localparam logic [7:0] REG_SP = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;

  // status_word flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_I = 2;
  localparam int FLAG_D = 3;
  localparam int FLAG_B = 4;
  localparam int FLAG_T = 5;
  localparam int FLAG_V = 6;
  localparam int FLAG_N = 7;

  // status after reset: interrupt disable set
  localparam logic [7:0] STATUS_RST = 8'h04;

  // command register fields, and the bit select taken from the operand
  localparam int CMD_OP_MSB = 4;
  localparam int CMD_TO_MEM_BIT = 5;
  localparam int BIT_SEL_MSB = 2;

  // address pages
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] ZERO_PAGE = 8'h00;

  // decimal adjust
  localparam logic [4:0] BCD_MAX = 5'h09;
  localparam logic [4:0] BCD_ADJ = 5'h06;

  typedef enum logic [4:0] {
    OP_ADD_WITH_CARRY = 5'h00,
    OP_SUBTRACT_WITH_BORROW = 5'h01,
    OP_AND = 5'h02,
    OP_EXCLUSIVE_OR = 5'h03,
    OP_INCLUSIVE_OR = 5'h04,
    OP_ARITH_SHIFT_LEFT = 5'h05,
    OP_LOGICAL_SHIFT_RIGHT = 5'h06,
    OP_ROTATE_LEFT_THROUGH_CARRY = 5'h07,
    OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h08,
    OP_ROTATE_RIGHT_NIBBLE = 5'h09,
    OP_ADD_ONE = 5'h0a,
    OP_SUBTRACT_ONE = 5'h0b,
    OP_BITWISE_INVERT = 5'h0c,
    OP_SET_MEMORY_BIT = 5'h0d,
    OP_CLEAR_MEMORY_BIT = 5'h0e,
    OP_PRODUCT = 5'h0f,
    OP_QUOTIENT = 5'h10,
    OP_PUSH_STATUS = 5'h11,
    OP_PULL_STATUS = 5'h12,
    OP_SET_CARRY_FLAG = 5'h13,
    OP_CLEAR_CARRY_FLAG = 5'h14,
    OP_SET_DECIMAL_FLAG = 5'h15,
    OP_CLEAR_DECIMAL_FLAG = 5'h16,
    OP_SET_INDEX_MODE = 5'h17,
    OP_CLEAR_INDEX_MODE = 5'h18
  } csf_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_READ = 3'b010,
    ST_MODIFY = 3'b011,
    ST_WRITE = 3'b100
  } csf_state_t;

endpackage

/* csf_rst_sync.sv */
/*
  reset release synchroniser: two flip-flops.
  assumes an active-low asynchronous reset input.
*/
`timescale 1ns/1ps
module csf_rst_sync (
  input wire logic i_clk,
  input wire logic i_resetn,
  output logic o_rst_n
);
  logic meta_ff;

  // assert at once, release after two edges
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_ff <= 1'b0;
      o_rst_n <= 1'b0;
    end else begin
      meta_ff <= 1'b1;
      o_rst_n <= meta_ff;
    end
  end
endmodule

/* csf_status_core.sv */
/*
  status-word core: accumulator, index, stack pointer and status_word,
  command-driven execution of alu, stack and read-modify-write sequences.
  assumes a memory port that returns read data the cycle after o_mem_re,
  and a register master that never reads and writes in the same cycle.
*/
// Implementation choices: the address map and strobed register access.
// How it works
// - reset sets interrupt disable, others don't-care
// - push_status to stack, pull_status restores it
// - decimal only for add and subtract_with_borrow
// - decimal n, v, z may be garbage
// - decimal carry on add, cleared on borrow
// - product and quotient ignore index and decimal
// - product and quotient keep status unchanged
// - memory ops read, modify, write same byte
// - index mode turns add, subtract, and, xor and or into read-modify-write
// - unreadable registers get arbitrary data, unprotected
`timescale 1ns/1ps
module csf_status_core (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_busy,
  output logic [7:0] o_status,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_mem_we,
  output logic o_mem_re,
  input wire logic [7:0] i_mem_rdata
);

  logic rst_n;
  csf_pkg::csf_state_t state_ff, nxt_state;
  csf_pkg::csf_op_t op_ff;
  csf_pkg::csf_op_t cmd_op;
  logic [7:0] acc_ff, x_ff, y_ff, sp_ff, status_ff;
  logic [7:0] operand_ff, addr_ff;
  logic [7:0] rdata_ff;
  logic busy_ff;
  logic [15:0] mem_addr_ff;
  logic [7:0] mem_wdata_ff;
  logic mem_we_ff, mem_re_ff;
  logic wr_idle;
  logic cmd_start;
  logic cmd_to_mem;
  logic cmd_is_mem;
  logic cmd_is_alu_pair;
  logic [15:0] cmd_target;
  logic [7:0] alu_a;
  logic [7:0] alu_res, alu_res_hi, alu_flags, alu_mask;
  logic [7:0] nxt_status_alu;

  // reset release through two flip-flops
  csf_rst_sync u_rst_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .o_rst_n(rst_n)
  );

  // register writes are taken only while idle
  assign wr_idle = i_wr && (state_ff == csf_pkg::ST_IDLE);
  assign cmd_start = wr_idle && (i_addr == csf_pkg::REG_CMD);
  assign cmd_op = csf_pkg::csf_op_t'(i_wdata[csf_pkg::CMD_OP_MSB:0]);
  assign cmd_to_mem = i_wdata[csf_pkg::CMD_TO_MEM_BIT];

  // accumulator-style alu ops that index mode redirects
  assign cmd_is_alu_pair = (cmd_op == csf_pkg::OP_ADD_WITH_CARRY) ||
                           (cmd_op == csf_pkg::OP_SUBTRACT_WITH_BORROW) ||
                           (cmd_op == csf_pkg::OP_AND) ||
                           (cmd_op == csf_pkg::OP_EXCLUSIVE_OR) ||
                           (cmd_op == csf_pkg::OP_INCLUSIVE_OR);

  // decide whether the command goes through memory
  always_comb begin
    cmd_is_mem = 1'b0;
    unique case (cmd_op)
      csf_pkg::OP_ADD_WITH_CARRY,
      csf_pkg::OP_SUBTRACT_WITH_BORROW,
      csf_pkg::OP_AND,
      csf_pkg::OP_EXCLUSIVE_OR,
      csf_pkg::OP_INCLUSIVE_OR: cmd_is_mem = status_ff[csf_pkg::FLAG_T];
      csf_pkg::OP_ARITH_SHIFT_LEFT,
      csf_pkg::OP_LOGICAL_SHIFT_RIGHT,
      csf_pkg::OP_ROTATE_LEFT_THROUGH_CARRY,
      csf_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY,
      csf_pkg::OP_ROTATE_RIGHT_NIBBLE,
      csf_pkg::OP_ADD_ONE,
      csf_pkg::OP_SUBTRACT_ONE,
      csf_pkg::OP_BITWISE_INVERT: cmd_is_mem = cmd_to_mem;
      csf_pkg::OP_SET_MEMORY_BIT,
      csf_pkg::OP_CLEAR_MEMORY_BIT: cmd_is_mem = 1'b1;
      default: cmd_is_mem = 1'b0;
    endcase
  end

  // zero page at X for the alu-pair ops in index mode, else zero page at addr
  assign cmd_target = (cmd_is_alu_pair && status_ff[csf_pkg::FLAG_T]) ?
                      {csf_pkg::ZERO_PAGE, x_ff} : {csf_pkg::ZERO_PAGE, addr_ff};

  // alu takes memory data while modifying, else the accumulator
  assign alu_a = (state_ff == csf_pkg::ST_MODIFY) ? i_mem_rdata : acc_ff;

  csf_alu u_alu (
    .i_op(op_ff),
    .i_a(alu_a),
    .i_m(operand_ff),
    .i_y(y_ff),
    .i_status(status_ff),
    .o_res(alu_res),
    .o_res_hi(alu_res_hi),
    .o_flags(alu_flags),
    .o_mask(alu_mask)
  );

  // merge alu flags into the status word where the op updates them
  assign nxt_status_alu = (status_ff & ~alu_mask) | (alu_flags & alu_mask);

  // sequencer next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      csf_pkg::ST_IDLE: begin
        if (cmd_start) begin
          if (cmd_op == csf_pkg::OP_PUSH_STATUS) begin
            nxt_state = csf_pkg::ST_WRITE;
          end else if (cmd_op == csf_pkg::OP_PULL_STATUS || cmd_is_mem) begin
            nxt_state = csf_pkg::ST_READ;
          end else begin
            nxt_state = csf_pkg::ST_EXEC;
          end
        end
      end
      csf_pkg::ST_EXEC: nxt_state = csf_pkg::ST_IDLE;
      csf_pkg::ST_READ: nxt_state = csf_pkg::ST_MODIFY;
      csf_pkg::ST_MODIFY: begin
        if (op_ff == csf_pkg::OP_PULL_STATUS) begin
          nxt_state = csf_pkg::ST_IDLE;
        end else begin
          nxt_state = csf_pkg::ST_WRITE;
        end
      end
      csf_pkg::ST_WRITE: nxt_state = csf_pkg::ST_IDLE;
      default: nxt_state = csf_pkg::ST_IDLE;
    endcase
  end

  // sequencer state and busy flag
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= csf_pkg::ST_IDLE;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= (nxt_state != csf_pkg::ST_IDLE);
    end
  end

  // latch the command opcode
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_ff <= csf_pkg::OP_ADD_WITH_CARRY;
    end else if (cmd_start) begin
      op_ff <= cmd_op;
    end
  end

  // memory port: strobes are single-cycle flops
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr_ff <= 16'h0000;
      mem_wdata_ff <= 8'h00;
      mem_we_ff <= 1'b0;
      mem_re_ff <= 1'b0;
    end else begin
      mem_we_ff <= 1'b0;
      mem_re_ff <= 1'b0;
      if (cmd_start) begin
        if (cmd_op == csf_pkg::OP_PUSH_STATUS) begin
          mem_addr_ff <= {csf_pkg::STACK_PAGE, sp_ff};
          mem_wdata_ff <= status_ff;
          mem_we_ff <= 1'b1;
        end else if (cmd_op == csf_pkg::OP_PULL_STATUS) begin
          mem_addr_ff <= {csf_pkg::STACK_PAGE, 8'(sp_ff + 8'h01)};
          mem_re_ff <= 1'b1;
        end else if (cmd_is_mem) begin
          mem_addr_ff <= cmd_target;
          mem_re_ff <= 1'b1;
        end
      end else if (state_ff == csf_pkg::ST_MODIFY && op_ff != csf_pkg::OP_PULL_STATUS) begin
        mem_wdata_ff <= alu_res;
        mem_we_ff <= 1'b1;
      end
    end
  end

  // stack pointer
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_ff <= 8'hff;
    end else if (cmd_start && cmd_op == csf_pkg::OP_PUSH_STATUS) begin
      sp_ff <= 8'(sp_ff - 8'h01);
    end else if (cmd_start && cmd_op == csf_pkg::OP_PULL_STATUS) begin
      sp_ff <= 8'(sp_ff + 8'h01);
    end else if (wr_idle && i_addr == csf_pkg::REG_SP) begin
      sp_ff <= i_wdata;
    end
  end

  // status word
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= csf_pkg::STATUS_RST;
    end else if (wr_idle && i_addr == csf_pkg::REG_STATUS) begin
      status_ff <= i_wdata;
    end else if (state_ff == csf_pkg::ST_MODIFY && op_ff == csf_pkg::OP_PULL_STATUS) begin
      status_ff <= i_mem_rdata;
    end else if (state_ff == csf_pkg::ST_EXEC || state_ff == csf_pkg::ST_MODIFY) begin
      status_ff <= nxt_status_alu;
    end
  end

  // accumulator and y: product and quotient fill both
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= 8'h00;
      y_ff <= 8'h00;
    end else if (wr_idle && i_addr == csf_pkg::REG_ACC) begin
      acc_ff <= i_wdata;
    end else if (wr_idle && i_addr == csf_pkg::REG_Y) begin
      y_ff <= i_wdata;
    end else if (state_ff == csf_pkg::ST_EXEC) begin
      acc_ff <= alu_res;
      y_ff <= alu_res_hi;
    end
  end

  // software-only registers: index, operand, address
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      x_ff <= 8'h00;
      operand_ff <= 8'h00;
      addr_ff <= 8'h00;
    end else if (wr_idle) begin
      if (i_addr == csf_pkg::REG_X) begin
        x_ff <= i_wdata;
      end
      if (i_addr == csf_pkg::REG_OPERAND) begin
        operand_ff <= i_wdata;
      end
      if (i_addr == csf_pkg::REG_ADDR) begin
        addr_ff <= i_wdata;
      end
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        csf_pkg::REG_CMD: rdata_ff <= {7'h00, busy_ff};
        csf_pkg::REG_OPERAND: rdata_ff <= operand_ff;
        csf_pkg::REG_ADDR: rdata_ff <= addr_ff;
        csf_pkg::REG_ACC: rdata_ff <= acc_ff;
        csf_pkg::REG_X: rdata_ff <= x_ff;
        csf_pkg::REG_Y: rdata_ff <= y_ff;
        csf_pkg::REG_SP: rdata_ff <= sp_ff;
        csf_pkg::REG_STATUS: rdata_ff <= status_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // outputs straight from flops
  assign o_rdata = rdata_ff;
  assign o_busy = busy_ff;
  assign o_status = status_ff;
  assign o_mem_addr = mem_addr_ff;
  assign o_mem_wdata = mem_wdata_ff;
  assign o_mem_we = mem_we_ff;
  assign o_mem_re = mem_re_ff;

endmodule

/* csf_status_core_chk.sv */
/*
  port checker for the status-word core: stack, multiply, rmw sequences.
  assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module csf_chk (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_busy,
  input wire logic [7:0] o_status,
  input wire logic [15:0] o_mem_addr,
  input wire logic [7:0] o_mem_wdata,
  input wire logic o_mem_we,
  input wire logic o_mem_re,
  input wire logic [7:0] i_mem_rdata
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // command taken on this edge
  logic go;
  logic [4:0] op;
  assign go = i_wr && !o_busy && (i_addr == csf_pkg::REG_CMD);
  assign op = i_wdata[4:0];
  property p_rst_i;
    $rose(i_resetn) |-> o_status == csf_pkg::STATUS_RST;
  endproperty
  a_rst_i: assert property (p_rst_i) else $error("status wrong after reset");
  property p_push;
    go && op == csf_pkg::OP_PUSH_STATUS |=> o_mem_we && !o_mem_re &&
      o_mem_addr[15:8] == csf_pkg::STACK_PAGE && o_mem_wdata == $past(o_status);
  endproperty
  a_push: assert property (p_push) else $error("push wrote wrong byte");
  property p_pull;
    go && op == csf_pkg::OP_PULL_STATUS |=> o_mem_re && o_mem_addr[15:8] == csf_pkg::STACK_PAGE
      ##2 o_status == $past(i_mem_rdata);
  endproperty
  a_pull: assert property (p_pull) else $error("pull did not restore status");
  property p_prod;
    go && op == csf_pkg::OP_PRODUCT |=> $stable(o_status) [*2];
  endproperty
  a_prod: assert property (p_prod) else $error("product changed status");
  property p_quot;
    go && op == csf_pkg::OP_QUOTIENT |=> !o_mem_re && !o_mem_we && $stable(o_status) ##1 $stable(o_status);
  endproperty
  a_quot: assert property (p_quot) else $error("quotient changed status");
  property p_rmw;
    go && i_wdata[5] && op inside {[5'h05:5'h0e]} |=> o_mem_re ##2 o_mem_we &&
      o_mem_addr == $past(o_mem_addr, 2);
  endproperty
  a_rmw: assert property (p_rmw) else $error("rmw sequence broken");
  property p_inv;
    go && i_wdata[5] && op == csf_pkg::OP_BITWISE_INVERT |=> ##2 o_mem_wdata == ~$past(i_mem_rdata);
  endproperty
  a_inv: assert property (p_inv) else $error("write back not from read data");
  property p_tmode;
    go && i_wdata[5] && o_status[csf_pkg::FLAG_T] && op <= 5'h04 |=> o_mem_re &&
      o_mem_addr[15:8] == csf_pkg::ZERO_PAGE ##2 o_mem_we && o_mem_addr == $past(o_mem_addr, 2);
  endproperty
  a_tmode: assert property (p_tmode) else $error("index mode op not rmw");
endmodule

bind csf_status_core csf_chk chk_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_busy(o_busy),
  .o_status(o_status), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
  .o_mem_we(o_mem_we), .o_mem_re(o_mem_re), .i_mem_rdata(i_mem_rdata));

/* csf_status_core_tb.sv */
/*
  self-checking bench for the status-word core with a byte memory model.
  assumes the checker is bound separately and a 100 MHz clock.
*/
`timescale 1ns/1ps
module csf_status_core_tb;
  logic i_clk, i_resetn, i_wr, i_rd, o_busy, o_mem_we, o_mem_re;
  logic [7:0] i_addr, i_wdata, o_rdata, o_status, o_mem_wdata, i_mem_rdata, d;
  logic [15:0] o_mem_addr;
  logic [7:0] mem [0:511];
  int failures, comparisons;
  localparam logic [7:0] EXP_M [10] = '{8'h02, 8'h01, 8'h02, 8'h01, 8'h10, 8'h11, 8'h10, 8'hef, 8'hff, 8'hef};
  localparam logic [4:0] T_OP [5] = '{5'h02, 5'h03, 5'h04, 5'h00, 5'h01};
  localparam logic [7:0] T_EXP [5] = '{8'h0c, 8'h30, 8'h3c, 8'h78, 8'h3c};

  csf_status_core dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_busy(o_busy), .o_status(o_status),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_mem_we(o_mem_we),
    .o_mem_re(o_mem_re), .i_mem_rdata(i_mem_rdata));

  // clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // memory: data only in the cycle after a read, else a changing pattern
  always @(posedge i_clk) begin
    if (o_mem_we) mem[o_mem_addr[8:0]] <= o_mem_wdata;
    i_mem_rdata <= o_mem_re ? mem[o_mem_addr[8:0]] : ~i_mem_rdata;
  end

  task stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t exp %h got %h", $time, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read one register; data stands only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  // read and compare a whole register
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(exp, d);
  endtask

  // read the status word and compare a single flag, other bits ignored
  task fchk(input int b, input logic e);
    rd(csf_pkg::REG_STATUS);
    chk({7'h00, e}, {7'h00, d[b]});
  endtask

  // issue a command and wait a bounded time for busy to fall
  task cmd(input logic [4:0] op, input logic m);
    int k;
    k = 0;
    wr(csf_pkg::REG_CMD, {2'b00, m, op});
    do begin
      @(posedge i_clk);
      #1;
      k++;
    end while (o_busy !== 1'b0 && k < 20);
    if (k >= 20) begin
      failures++;
      stop_test;
    end
  endtask

  task do_reset;
    i_resetn <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask

  task t_flags;
    wr(csf_pkg::REG_STATUS, 8'h00);
    for (int i = 0; i < 6; i++) begin
      cmd(5'h13 + 5'(i), 1'b0);
      fchk(i < 2 ? csf_pkg::FLAG_C : (i < 4 ? csf_pkg::FLAG_D : csf_pkg::FLAG_T), ~i[0]);
    end
  endtask

  task t_stack;
    wr(csf_pkg::REG_STATUS, 8'ha5);
    cmd(csf_pkg::OP_PUSH_STATUS, 1'b0);
    rchk(csf_pkg::REG_SP, 8'hfe);
    chk(8'ha5, mem[9'h1ff]);
    wr(csf_pkg::REG_STATUS, 8'h00);
    cmd(csf_pkg::OP_PULL_STATUS, 1'b0);
    rchk(csf_pkg::REG_STATUS, 8'ha5);
    rchk(csf_pkg::REG_SP, 8'hff);
  endtask

  task t_decimal;
    wr(csf_pkg::REG_STATUS, 8'h08);
    wr(csf_pkg::REG_ACC, 8'h58);
    wr(csf_pkg::REG_OPERAND, 8'h46);
    cmd(csf_pkg::OP_ADD_WITH_CARRY, 1'b0);
    rchk(csf_pkg::REG_ACC, 8'h04);
    fchk(csf_pkg::FLAG_C, 1'b1);
    wr(csf_pkg::REG_STATUS, 8'h09);
    wr(csf_pkg::REG_ACC, 8'h12);
    wr(csf_pkg::REG_OPERAND, 8'h34);
    cmd(csf_pkg::OP_SUBTRACT_WITH_BORROW, 1'b0);
    rchk(csf_pkg::REG_ACC, 8'h78);
    fchk(csf_pkg::FLAG_C, 1'b0);
    wr(csf_pkg::REG_ACC, 8'h09);
    cmd(csf_pkg::OP_ADD_ONE, 1'b0);
    rchk(csf_pkg::REG_ACC, 8'h0a);
  endtask

  // same results with index and decimal flags clear and set
  task t_muldiv;
    for (int j = 0; j < 2; j++) begin
      wr(csf_pkg::REG_STATUS, j ? 8'h29 : 8'h00);
      wr(csf_pkg::REG_ACC, 8'h12);
      wr(csf_pkg::REG_OPERAND, 8'h34);
      cmd(csf_pkg::OP_PRODUCT, 1'b0);
      rchk(csf_pkg::REG_ACC, 8'ha8);
      rchk(csf_pkg::REG_Y, 8'h03);
      wr(csf_pkg::REG_OPERAND, 8'h35);
      cmd(csf_pkg::OP_QUOTIENT, 1'b0);
      rchk(csf_pkg::REG_ACC, 8'h11);
      rchk(csf_pkg::REG_Y, 8'h23);
      wr(csf_pkg::REG_OPERAND, 8'h00);
      cmd(csf_pkg::OP_QUOTIENT, 1'b0);
      rchk(csf_pkg::REG_ACC, 8'hff);
      rchk(csf_pkg::REG_STATUS, j ? 8'h29 : 8'h00);
    end
  endtask

  task t_rmw;
    wr(csf_pkg::REG_STATUS, 8'h00);
    wr(csf_pkg::REG_ACC, 8'h5a);
    wr(csf_pkg::REG_ADDR, 8'h40);
    wr(csf_pkg::REG_OPERAND, 8'h04);
    mem[9'h040] = 8'h81;
    for (int i = 0; i < 10; i++) begin
      cmd(5'h05 + 5'(i), 1'b1);
      chk(EXP_M[i], mem[9'h040]);
    end
    rchk(csf_pkg::REG_ACC, 8'h5a);
  endtask

  task t_tmode;
    wr(csf_pkg::REG_STATUS, 8'h20);
    wr(csf_pkg::REG_X, 8'h30);
    wr(csf_pkg::REG_OPERAND, 8'h3c);
    mem[9'h030] = 8'h0f;
    mem[9'h040] = 8'h00;
    for (int i = 0; i < 5; i++) begin
      if (i == 4) cmd(csf_pkg::OP_SET_CARRY_FLAG, 1'b0);
      cmd(T_OP[i], 1'b1);
      chk(T_EXP[i], mem[9'h030]);
    end
    rchk(csf_pkg::REG_ACC, 8'h5a);
    chk(8'h00, mem[9'h040]);
  endtask

  initial begin
    i_resetn = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_mem_rdata = 8'h00;
    failures = 0;
    comparisons = 0;
    for (int k = 0; k < 512; k++) mem[k] = 8'h00;
    do_reset;
    rchk(csf_pkg::REG_STATUS, csf_pkg::STATUS_RST);
    rchk(8'h20, 8'h00);
    t_flags;
    t_stack;
    t_decimal;
    t_muldiv;
    t_rmw;
    t_tmode;
    wr(csf_pkg::REG_STATUS, 8'hff);
    do_reset;
    rchk(csf_pkg::REG_STATUS, csf_pkg::STATUS_RST);
    stop_test;
  end
endmodule
